// File: rtl/clk_ctrl_pkg.sv
/*
 * package for the clock mode and standby controller: register offsets,
 * field positions, reset values, mode encodings and packed carriers.
 * assumes nothing of its surroundings.
 */
package clk_ctrl_pkg;

   // ***********************************************************************
   // register map (byte addresses on the apb bus)
   // ***********************************************************************
   localparam logic [7:0] DIVIDE_RATIO_CTRL_ADDR    = 8'h00;
   localparam logic [7:0] STANDBY_CTRL_ADDR         = 8'h04;
   localparam logic [7:0] OSC_ENABLE_MODE_CTRL_ADDR = 8'h08;
   localparam logic [7:0] STAB_WAIT_SETTING_ADDR    = 8'h0C;
   localparam logic [7:0] CLOCK_STATUS_ADDR         = 8'h10;

   // ***********************************************************************
   // field positions
   // ***********************************************************************
   localparam int DIV_LSB       = 0;   // divide ratio, 2 bits
   localparam int RCFREQ_LSB    = 2;   // main rc frequency select, 2 bits
   localparam int STBY_LSB      = 0;   // standby request, 3 bits
   localparam int PINHIZ_BIT    = 3;   // pins hi-z in stop/tbt/watch
   localparam int SWRST_BIT     = 4;   // software reset
   localparam int MODE_LSB      = 0;   // requested clock mode, 2 bits
   localparam int OSCEN_LSB     = 4;   // oscillation enables, 4 bits
   localparam int MWAIT_LSB     = 0;   // main wait select, 4 bits
   localparam int SWAIT_LSB     = 4;   // sub wait select, 4 bits
   localparam int CURMODE_LSB   = 0;   // mode in effect, 2 bits
   localparam int BUSY_BIT      = 2;   // switch pending
   localparam int STABOK_LSB    = 4;   // per-source stable flags, 4 bits

   // ***********************************************************************
   // reset values
   // ***********************************************************************
   localparam logic [3:0] DIVIDE_RATIO_RST = 4'h0;
   localparam logic [1:0] CLOCK_MODE_RST   = 2'h1;
   localparam logic [3:0] OSC_ENABLE_RST   = 4'h2;
   localparam logic [7:0] STAB_WAIT_RST    = 8'hFF;
   localparam int         STAB_CNT_W       = 16;
   localparam int         MAIN_WAIT_MAX    = 13;   // 14 selections
   localparam int         SUB_WAIT_MAX     = 14;   // 15 selections
   localparam int         SWRST_CYCLES     = 4;

   typedef enum logic [1:0] {
      MODE_MAIN_OSC = 2'h0,
      MODE_MAIN_RC  = 2'h1,
      MODE_SUB_OSC  = 2'h2,
      MODE_SUB_RC   = 2'h3
   } clk_mode_e;

   typedef enum logic [2:0] {
      STBY_RUN   = 3'h0,
      STBY_SLEEP = 3'h1,
      STBY_TBT   = 3'h3,
      STBY_WATCH = 3'h2,
      STBY_STOP  = 3'h6
   } stby_mode_e;

   // per-source oscillation enables, bit order matches clk_mode_e codes
   typedef struct packed {
      logic sub_rc;
      logic sub_osc;
      logic main_rc;
      logic main_osc;
   } osc_en_s;

   // clock gate enables to the consumers
   typedef struct packed {
      logic cpu;
      logic periph;
      logic tbt;
      logic watch_pre;
      logic wdt;
   } gate_s;

   function automatic logic is_main_mode(input clk_mode_e m);
      is_main_mode = (m == MODE_MAIN_OSC) || (m == MODE_MAIN_RC);
   endfunction : is_main_mode

endpackage : clk_ctrl_pkg

// File: rtl/clock_mode_standby_controller.sv
/*
 * clock mode and standby controller: source selection, machine clock
 * prescaler, standby gating, wait timing and the apb register file.
 * assumes every source arrives as a one-cycle enable pulse on I_CLK,
 * and wakeup events are synchronous pulses.
 */
`timescale 1ns/1ps

// Contract
// - main mode: machine clock from main oscillator divided by two.
// - main rc mode: machine clock from trimmed main rc oscillator.
// - sub mode: machine clock from sub oscillator divided by two.
// - sub rc mode: machine clock from sub rc oscillator.
// - selector picks one of four sources, then prescaler forms machine clock.
// - selected clock divisible by programmable ratio; main rc frequency selectable.
// - gate cpu and peripheral clocks by standby mode and wait status.
// - stabilization timer: 14 main waits, 15 sub waits, drives done.
// - divide ratio register holds the machine clock division.
// - standby register: mode request, pin states, software reset.
// - osc/mode register: four enables, mode select, requested mode readback; current mode reads back from status.
// - wait setting register: separate main and sub selections.
// - sleep stops cpu clock only; here the watchdog clock also stops unless the watchdog is started.
// - time-base timer mode clocks only time-base timer and watch prescaler.
// - time-base timer mode allowed only in main or main rc mode.
// - watch mode halts main oscillation, clocks only watch prescaler.
// - watch mode allowed only in sub or sub rc mode.
// - stop halts main and sub oscillation and all clocks.
// - sleep and stop allowed in any clock mode.
// - watchdog clock from time-base timer on main, watch prescaler on sub.
// - outside main mode main oscillator runs only if its enable is one or main mode is requested.
// - started watchdog keeps its clock in standby other than stop.
module clock_mode_standby_controller
   import clk_ctrl_pkg::*;
(
   input  wire logic        I_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_MAIN_OSC_TICK,
   input  wire logic        I_SUB_OSC_TICK,
   input  wire logic        I_MAIN_RC_TICK,
   input  wire logic        I_SUB_RC_TICK,
   input  wire logic        I_TBT_TICK,
   input  wire logic        I_WATCH_PRE_TICK,
   input  wire logic        I_WAKEUP,
   input  wire logic        I_WDT_STARTED,
   output osc_en_s          O_OSC_RUN,
   output logic [1:0]       O_RC_FREQ_SEL,
   output gate_s            O_GATE,
   output logic             O_CPU_CLK_EN,
   output logic             O_PERIPH_CLK_EN,
   output logic             O_WDT_CLK_EN,
   output logic             O_PIN_HIZ,
   output logic             O_SW_RESET
);

   // ***********************************************************************
   // registers
   // ***********************************************************************
   logic [3:0]  divide_ratio_ctrl_reg;
   stby_mode_e  stby_reg;
   stby_mode_e  stby_next;
   logic        pin_hiz_reg;
   logic [2:0]  swrst_cnt_reg;
   clk_mode_e   req_mode_reg;
   osc_en_s     osc_en_reg;
   logic [7:0]  stab_wait_reg;
   logic [4:0]  pre_cnt_reg;
   logic        main_half_reg;
   logic        sub_half_reg;
   logic        cpu_en_reg;
   logic        periph_en_reg;
   logic        wdt_en_reg;
   logic [31:0] prdata_reg;

   // ***********************************************************************
   // apb decode
   // ***********************************************************************
   wire access   = I_PSEL && I_PENABLE;
   wire wr       = access && I_PWRITE;
   wire hit_div  = (I_PADDR == DIVIDE_RATIO_CTRL_ADDR);
   wire hit_stby = (I_PADDR == STANDBY_CTRL_ADDR);
   wire hit_osc  = (I_PADDR == OSC_ENABLE_MODE_CTRL_ADDR);
   wire hit_wait = (I_PADDR == STAB_WAIT_SETTING_ADDR);
   wire hit_stat = (I_PADDR == CLOCK_STATUS_ADDR);
   wire mapped   = hit_div || hit_stby || hit_osc || hit_wait || hit_stat;

   // status is read only; writes to it are errors as well
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = access && (!mapped || (I_PWRITE && hit_stat));
   assign O_PRDATA  = prdata_reg;

   // ***********************************************************************
   // source ticks
   // ***********************************************************************
   // oscillator half-rate taps; only every second tick passes
   wire main_half_tick = I_MAIN_OSC_TICK && main_half_reg;
   wire sub_half_tick  = I_SUB_OSC_TICK && sub_half_reg;
   wire [3:0] src_tick = {I_SUB_RC_TICK, sub_half_tick, I_MAIN_RC_TICK, main_half_tick};

   clk_mode_e  cur_mode;
   logic       switch_busy;
   logic       sel_tick;
   logic [3:0] stable;
   osc_en_s    osc_run;

   // ***********************************************************************
   // standby and oscillator control
   // ***********************************************************************
   wire stby_wr    = wr && hit_stby;
   wire [2:0] stby_req = I_PWDATA[STBY_LSB +: 3];
   wire main_cur   = is_main_mode(cur_mode);
   // tbt only from main modes, watch only from sub modes
   wire tbt_ok     = (stby_req == STBY_TBT) && main_cur;
   wire watch_ok   = (stby_req == STBY_WATCH) && !main_cur;
   wire any_ok     = (stby_req == STBY_SLEEP) || (stby_req == STBY_STOP);
   wire stby_take  = stby_wr && (stby_reg == STBY_RUN) && (tbt_ok || watch_ok || any_ok);

   always_comb begin
      stby_next = stby_reg;
      if (I_WAKEUP) begin
         stby_next = STBY_RUN;
      end else if (stby_take) begin
         stby_next = stby_mode_e'(stby_req);
      end
   end

   wire in_stop  = (stby_reg == STBY_STOP);
   wire in_watch = (stby_reg == STBY_WATCH);

   // active and requested sources run; others by enable; main halted in watch/stop, all in stop
   always_comb begin
      osc_run          = osc_en_reg;
      osc_run[cur_mode] = 1'b1;
      osc_run[req_mode_reg] = 1'b1;
      // main oscillator outside main mode obeys its enable unless main mode is requested
      osc_run.main_osc = (cur_mode == MODE_MAIN_OSC || req_mode_reg == MODE_MAIN_OSC)
                         || osc_en_reg.main_osc;
      if (in_watch || in_stop) begin
         osc_run.main_osc = 1'b0;
         osc_run.main_rc  = 1'b0;
      end
      if (in_stop) begin
         osc_run.sub_osc = 1'b0;
         osc_run.sub_rc  = 1'b0;
      end
   end

   // ***********************************************************************
   // sub blocks
   // ***********************************************************************
   stab_wait_timer u_wait (
      .i_clk      (I_CLK),
      .i_rst      (I_RST),
      .i_osc_run  (osc_run),
      .i_main_sel (stab_wait_reg[MWAIT_LSB +: 4]),
      .i_sub_sel  (stab_wait_reg[SWAIT_LSB +: 4]),
      .o_stable   (stable)
   );

   glitch_free_mux u_mux (
      .i_clk      (I_CLK),
      .i_rst      (I_RST),
      .i_req_mode (req_mode_reg),
      .i_stable   (stable),
      .i_src_tick (src_tick),
      .o_cur_mode (cur_mode),
      .o_busy     (switch_busy),
      .o_tick     (sel_tick)
   );

   // ***********************************************************************
   // prescaler
   // ***********************************************************************
   // ratio 0..3 gives divide by 1,4,8,16 of the selected source
   function automatic logic [4:0] div_limit(input logic [1:0] r);
      div_limit = (r == 2'h0) ? 5'h00 : 5'((5'h01 << (3'(r) + 3'h1)) - 5'h01);
   endfunction : div_limit

   wire [4:0] lim        = div_limit(divide_ratio_ctrl_reg[DIV_LSB +: 2]);
   wire       pre_wrap   = sel_tick && (pre_cnt_reg >= lim);
   wire       src_stable = stable[cur_mode];

   // ***********************************************************************
   // gating
   // ***********************************************************************
   // no machine clock until its source is stable
   wire run_ok    = src_stable && (stby_reg == STBY_RUN);
   wire per_ok    = src_stable && (stby_reg == STBY_RUN || stby_reg == STBY_SLEEP);
   wire tbt_clk   = (stby_reg == STBY_RUN || stby_reg == STBY_SLEEP || stby_reg == STBY_TBT)
                    && main_cur;
   wire watch_clk = !in_stop;
   // watchdog source by mode, alive in standby other than stop once started
   wire wdt_src   = main_cur ? I_TBT_TICK : I_WATCH_PRE_TICK;
   wire wdt_ok    = ((stby_reg == STBY_RUN) || I_WDT_STARTED) && !in_stop;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         divide_ratio_ctrl_reg <= DIVIDE_RATIO_RST;
         stby_reg              <= STBY_RUN;
         pin_hiz_reg           <= 1'b0;
         swrst_cnt_reg         <= '0;
         req_mode_reg          <= clk_mode_e'(CLOCK_MODE_RST);
         osc_en_reg            <= OSC_ENABLE_RST;
         stab_wait_reg         <= STAB_WAIT_RST;
         pre_cnt_reg           <= '0;
         main_half_reg         <= 1'b0;
         sub_half_reg          <= 1'b0;
         cpu_en_reg            <= 1'b0;
         periph_en_reg         <= 1'b0;
         wdt_en_reg            <= 1'b0;
         prdata_reg            <= '0;
      end else begin
         if (I_MAIN_OSC_TICK) main_half_reg <= !main_half_reg;
         if (I_SUB_OSC_TICK) sub_half_reg <= !sub_half_reg;
         if (wr && hit_div) begin
            divide_ratio_ctrl_reg <= I_PWDATA[3:0];
         end
         if (wr && hit_osc) begin
            req_mode_reg <= clk_mode_e'(I_PWDATA[MODE_LSB +: 2]);
            osc_en_reg   <= I_PWDATA[OSCEN_LSB +: 4];
         end
         if (wr && hit_wait) begin
            stab_wait_reg <= I_PWDATA[7:0];
         end
         stby_reg <= stby_next;
         if (stby_wr) begin
            pin_hiz_reg <= I_PWDATA[PINHIZ_BIT];
         end
         if (stby_wr && I_PWDATA[SWRST_BIT]) begin
            swrst_cnt_reg <= 3'(SWRST_CYCLES);
         end else if (swrst_cnt_reg != 3'h0) begin
            swrst_cnt_reg <= swrst_cnt_reg - 3'h1;
         end
         if (sel_tick) begin
            pre_cnt_reg <= pre_wrap ? 5'h00 : pre_cnt_reg + 5'h01;
         end
         cpu_en_reg    <= pre_wrap && run_ok;
         periph_en_reg <= pre_wrap && per_ok;
         wdt_en_reg    <= wdt_src && wdt_ok;
         // loaded in setup so read data stands at the access edge
         if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            prdata_reg <= '0;
            unique case (1'b1)
               hit_div:  prdata_reg[3:0] <= divide_ratio_ctrl_reg;
               hit_stby: prdata_reg[4:0] <= {1'b0, pin_hiz_reg, stby_reg};
               hit_osc:  prdata_reg[7:0] <= {osc_en_reg, 2'h0, req_mode_reg};
               hit_wait: prdata_reg[7:0] <= stab_wait_reg;
               hit_stat: prdata_reg[7:0] <= {stable, 1'b0, switch_busy, cur_mode};
               default:  prdata_reg <= '0;
            endcase
         end
      end
   end

   // ***********************************************************************
   // outputs
   // ***********************************************************************
   // main rc frequency select only steers that oscillator
   assign O_RC_FREQ_SEL   = divide_ratio_ctrl_reg[RCFREQ_LSB +: 2];
   assign O_OSC_RUN       = osc_run;
   assign O_CPU_CLK_EN    = cpu_en_reg;
   assign O_PERIPH_CLK_EN = periph_en_reg;
   assign O_WDT_CLK_EN    = wdt_en_reg;
   assign O_GATE          = '{cpu: cpu_en_reg, periph: periph_en_reg,
                              tbt: tbt_clk && I_TBT_TICK,
                              watch_pre: watch_clk && I_WATCH_PRE_TICK,
                              wdt: wdt_en_reg};
   assign O_PIN_HIZ       = pin_hiz_reg && (stby_reg == STBY_STOP || stby_reg == STBY_TBT
                            || stby_reg == STBY_WATCH);
   assign O_SW_RESET      = (swrst_cnt_reg != 3'h0);

endmodule : clock_mode_standby_controller

// File: rtl/glitch_free_mux.sv
/*
 * glitch-free selector of the source clock enable: the old source is
 * released first, the new one taken only once stable.
 * assumes sources are enable pulses in the single system clock domain.
 */
`timescale 1ns/1ps
module glitch_free_mux
   import clk_ctrl_pkg::*;
(
   input  wire logic      i_clk,
   input  wire logic      i_rst,
   input  wire clk_mode_e i_req_mode,
   input  wire logic [3:0] i_stable,
   input  wire logic [3:0] i_src_tick,
   output clk_mode_e      o_cur_mode,
   output logic           o_busy,
   output logic           o_tick
);

   clk_mode_e cur_reg;
   clk_mode_e cur_next;

   // switch only once the target has finished its wait
   wire switch_ok = (i_req_mode != cur_reg) && i_stable[i_req_mode];
   // move at an old-source tick, or at once if the old source is not stable, so no partial period leaks out
   wire at_edge   = i_src_tick[cur_reg] || !i_stable[cur_reg];

   assign cur_next = (switch_ok && at_edge) ? i_req_mode : cur_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cur_reg <= clk_mode_e'(CLOCK_MODE_RST);
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign o_cur_mode = cur_reg;
   assign o_busy     = (i_req_mode != cur_reg);
   assign o_tick     = i_src_tick[cur_reg] && !(switch_ok && at_edge);

endmodule : glitch_free_mux

// File: rtl/stab_wait_timer.sv
/*
 * oscillation stabilization wait timer: one free counter per source,
 * started by its enable; done when the selected tap bit is reached.
 * assumes enables and the selection come from the same clock domain.
 */
`timescale 1ns/1ps
module stab_wait_timer
   import clk_ctrl_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire osc_en_s    i_osc_run,
   input  wire logic [3:0] i_main_sel,
   input  wire logic [3:0] i_sub_sel,
   output logic [3:0]      o_stable
);

   // ***********************************************************************
   // counters
   // ***********************************************************************
   logic [STAB_CNT_W-1:0] cnt_reg [4];
   logic [3:0]            stable_reg;
   logic [3:0]            tap;
   logic [3:0]            run;

   // main selections saturate at 14 taps, sub at 15
   wire [3:0] main_tap = (i_main_sel > 4'(MAIN_WAIT_MAX)) ? 4'(MAIN_WAIT_MAX) : i_main_sel;
   wire [3:0] sub_tap  = (i_sub_sel > 4'(SUB_WAIT_MAX)) ? 4'(SUB_WAIT_MAX) : i_sub_sel;

   assign run = i_osc_run;

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         tap[k] = (k < 2) ? cnt_reg[k][main_tap + 4'h1] : cnt_reg[k][sub_tap + 4'h1];
      end
   end

   always_ff @(posedge i_clk) begin
      for (int k = 0; k < 4; k++) begin
         if (i_rst || !run[k]) begin
            cnt_reg[k]    <= '0;
            stable_reg[k] <= 1'b0;
         end else if (!stable_reg[k]) begin
            cnt_reg[k]    <= cnt_reg[k] + 1'b1;
            stable_reg[k] <= tap[k];
         end
      end
   end

   assign o_stable = stable_reg;

endmodule : stab_wait_timer

// File: testbench/clock_mode_standby_controller_bench.sv
/*
 * self-checking bench: apb register access, mode switching, machine
 * clock rates, standby gating and software reset.
 * assumes source ticks on fixed periods and apb read data at the access edge.
 */
`timescale 1ns/1ps
module clock_mode_standby_controller_bench
   import clk_ctrl_pkg::*;
;
   logic        clk, rst, psel, penable, pwrite, wakeup, wdt_on, want, rd_seen;
   logic        pready, pslverr, cpu_en, per_en, wdt_en, pin_hiz, sw_rst, tbt_t, wpre_t;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r, v;
   logic [3:0]  tick, b;
   logic [1:0]  rc_sel;
   osc_en_s     osc_run;
   gate_s       gate;
   logic [31:0] exp_q[$];
   int          miscompares, samples_checked, cyc, n_cpu, n_per, n_aux, n_wdt, n_sw, aux_sel;
   int          per[4] = '{4, 3, 10, 7};
   int          rat[4] = '{1, 4, 8, 16};
   clk_mode_e   mseq[4] = '{MODE_MAIN_OSC, MODE_SUB_OSC, MODE_SUB_RC, MODE_MAIN_RC};
   stby_mode_e  scode[4] = '{STBY_SLEEP, STBY_TBT, STBY_WATCH, STBY_STOP};
   logic [2:0]  sexp[2][4] = '{'{3'h3, 3'h1, 3'h7, 3'h0}, '{3'h3, 3'h7, 3'h1, 3'h0}};

   clock_mode_standby_controller dut (
      .I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_MAIN_OSC_TICK(tick[0]), .I_MAIN_RC_TICK(tick[1]),
      .I_SUB_OSC_TICK(tick[2]), .I_SUB_RC_TICK(tick[3]), .I_TBT_TICK(tbt_t),
      .I_WATCH_PRE_TICK(wpre_t), .I_WAKEUP(wakeup), .I_WDT_STARTED(wdt_on),
      .O_OSC_RUN(osc_run), .O_RC_FREQ_SEL(rc_sel), .O_GATE(gate), .O_CPU_CLK_EN(cpu_en),
      .O_PERIPH_CLK_EN(per_en), .O_WDT_CLK_EN(wdt_en), .O_PIN_HIZ(pin_hiz),
      .O_SW_RESET(sw_rst));

   // ***********************************************************************
   // tasks
   // ***********************************************************************
   task automatic complete_run;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // the expectation is queued; the watcher compares when data appears
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      want = 1'b1;
      apb(a, 1'b0, 32'h0);
      want = 1'b0;
   endtask : rd_chk

   // counts are taken on the falling edge, so snapshots never race
   task automatic measure(input int w);
      int c0, p0, x0, w0;
      c0 = n_cpu; p0 = n_per; x0 = n_aux; w0 = n_wdt;
      repeat (w) @(posedge clk);
      b = {n_cpu != c0, n_per != p0, n_aux != x0, n_wdt != w0};
   endtask : measure

   task automatic go_mode(input clk_mode_e m);
      apb(OSC_ENABLE_MODE_CTRL_ADDR, 1'b1, {24'h0, 4'hF, 2'h0, m});
      repeat (300) begin
         apb(CLOCK_STATUS_ADDR, 1'b0, 32'h0);
         if (r[2:0] == {1'b0, m}) break;
      end
      cmp({29'h0, r[2:0]}, {29'h0, 1'b0, m});
   endtask : go_mode

   // ***********************************************************************
   // clock, sources, counters, read watcher
   // ***********************************************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      tick <= {cyc % 7 == 0, cyc % 5 == 0, cyc % 3 == 0, cyc % 2 == 0};
      tbt_t <= ($urandom % 4) == 0;
      wpre_t <= ($urandom % 4) == 0;
      rd_seen <= psel && penable && !pwrite && want;
      if (rd_seen) cmp(prdata, exp_q.pop_front());
      if (cyc == 90000) begin
         miscompares++;
         complete_run();
      end
   end

   always @(negedge clk) begin
      n_cpu += cpu_en;
      n_per += per_en;
      n_aux += aux_sel ? gate.watch_pre : gate.tbt;
      n_wdt += wdt_en;
      n_sw += sw_rst;
   end

   // ***********************************************************************
   // main sequence
   // ***********************************************************************
   initial begin
      {psel, penable, pwrite, wakeup, wdt_on, want} = '0;
      {paddr, pwdata} = '0;
      rst = 1'b1;
      void'($urandom(32'hbef28076));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(DIVIDE_RATIO_CTRL_ADDR, {28'h0, DIVIDE_RATIO_RST});
      rd_chk(OSC_ENABLE_MODE_CTRL_ADDR, {24'h0, OSC_ENABLE_RST, 2'h0, CLOCK_MODE_RST});
      rd_chk(STAB_WAIT_SETTING_ADDR, {24'h0, STAB_WAIT_RST});
      rd_chk(8'h14, 32'h0);
      repeat (4) begin
         v = {24'h0, 4'($urandom_range(SUB_WAIT_MAX)), 4'($urandom_range(MAIN_WAIT_MAX))};
         apb(STAB_WAIT_SETTING_ADDR, 1'b1, v);
         rd_chk(STAB_WAIT_SETTING_ADDR, v);
      end
      apb(STAB_WAIT_SETTING_ADDR, 1'b1, 32'h0);
      // shortest waits keep the switches quick; long taps only read back
      foreach (mseq[i]) begin
         go_mode(mseq[i]);
         for (int k = 0; k < 4; k++) begin
            v = {28'h0, 2'($urandom), 2'(k)};
            apb(DIVIDE_RATIO_CTRL_ADDR, 1'b1, v);
            rd_chk(DIVIDE_RATIO_CTRL_ADDR, v);
            v = n_per;
            measure(1680);
            v = n_per - v - 1680 / (per[mseq[i]] * rat[k]);
            cmp(32'(v + 1 <= 2), 32'h1);
         end
      end
      apb(DIVIDE_RATIO_CTRL_ADDR, 1'b1, 32'h0);
      for (int j = 0; j < 2; j++) begin
         go_mode(j ? MODE_SUB_RC : MODE_MAIN_RC);
         aux_sel = j;
         wdt_on <= j[0];
         if (j == 0) cmp(32'(osc_run), 32'hF);
         foreach (scode[i]) begin
            apb(STANDBY_CTRL_ADDR, 1'b1, {28'h0, 1'b1, scode[i]});
            measure(200);
            cmp(32'(b[3:1]), 32'(sexp[j][i]));
            // stop gates every clock, the started watchdog's too
            if (j == 1) cmp(32'(b[0]), 32'(scode[i] != STBY_STOP));
            cmp(32'(pin_hiz), 32'(scode[i] == STBY_STOP || scode[i] == (j ? STBY_WATCH : STBY_TBT)));
            if (scode[i] == STBY_STOP) cmp(32'({osc_run.sub_osc, osc_run.main_osc}), 0);
            if (j == 1 && scode[i] == STBY_WATCH) cmp(32'(osc_run.main_osc), 0);
            wakeup <= 1'b1;
            @(posedge clk);
            wakeup <= 1'b0;
            repeat (100) @(posedge clk);
         end
      end
      v = n_sw;
      apb(STANDBY_CTRL_ADDR, 1'b1, 32'h10);
      repeat (20) @(posedge clk);
      cmp(n_sw - v, SWRST_CYCLES);
      complete_run();
   end
endmodule : clock_mode_standby_controller_bench

// File: testbench/clock_mode_standby_controller_monitor.sv
/*
 * port checker for the clock mode and standby controller.
 * assumes one clock domain and apb read data loaded in the setup cycle.
 */
`timescale 1ns/1ps
module clock_mode_standby_controller_monitor
   import clk_ctrl_pkg::*;
(
   input wire logic        I_CLK,
   input wire logic        I_RST,
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic [7:0]  I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] O_PRDATA,
   input wire logic        O_PREADY,
   input wire logic        O_PSLVERR,
   input wire logic        I_TBT_TICK,
   input wire logic        I_WATCH_PRE_TICK,
   input wire logic [1:0]  O_RC_FREQ_SEL,
   input wire gate_s       O_GATE,
   input wire logic        O_CPU_CLK_EN,
   input wire logic        O_PERIPH_CLK_EN,
   input wire logic        O_WDT_CLK_EN,
   input wire logic        O_SW_RESET
);
   // ***********************************************************************
   // properties
   // ***********************************************************************
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   sequence s_div_write;
      I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == DIVIDE_RATIO_CTRL_ADDR;
   endsequence
   chk_ready_high: assert property (I_PSEL |-> O_PREADY)
      else $error("ready low during a transfer");
   chk_slverr_unmapped: assert property (I_PSEL && I_PENABLE && I_PADDR > CLOCK_STATUS_ADDR
                                         |-> O_PSLVERR)
      else $error("no error on unmapped address");
   chk_rcfreq_write: assert property (s_div_write |=> O_RC_FREQ_SEL == $past(I_PWDATA[3:2]))
      else $error("rc frequency select not taken");
   chk_prdata_hold: assert property (!(I_PSEL && !I_PENABLE && !I_PWRITE) |=> $stable(O_PRDATA))
      else $error("read data moved without a read");
   chk_swrst_width: assert property ($rose(O_SW_RESET) |-> O_SW_RESET[*4] ##1 !O_SW_RESET)
      else $error("software reset width wrong");
   chk_tbt_gate: assert property (O_GATE.tbt |-> I_TBT_TICK)
      else $error("time-base gate without its tick");
   chk_watch_gate: assert property (O_GATE.watch_pre |-> I_WATCH_PRE_TICK)
      else $error("watch prescaler gate without its tick");
   chk_wdt_source: assert property (O_WDT_CLK_EN |-> $past(I_TBT_TICK) || $past(I_WATCH_PRE_TICK))
      else $error("watchdog enable without a source tick");
   chk_cpu_periph: assert property (O_CPU_CLK_EN |-> O_PERIPH_CLK_EN)
      else $error("cpu clocked while peripherals gated");
endmodule : clock_mode_standby_controller_monitor

bind clock_mode_standby_controller clock_mode_standby_controller_monitor mon (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
   .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
   .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_TBT_TICK(I_TBT_TICK),
   .I_WATCH_PRE_TICK(I_WATCH_PRE_TICK), .O_RC_FREQ_SEL(O_RC_FREQ_SEL), .O_GATE(O_GATE),
   .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN),
   .O_WDT_CLK_EN(O_WDT_CLK_EN), .O_SW_RESET(O_SW_RESET));
